// ### src/scct_timer.sv
`timescale 1ns/10ps
`default_nettype none
module scct_timer (
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  // CPU bus
  input  wire logic [scct_pkg::AW-1:0]       bus_addr_in,
  input  wire logic                          bus_wr_in,
  input  wire logic                          bus_rd_in,
  input  wire logic [1:0]                    bus_be_in,
  input  wire logic [scct_pkg::DW-1:0]       bus_wdata_in,
  output logic      [scct_pkg::DW-1:0]       bus_rdata_out,
  // Timer pins
  input  wire logic [2*scct_pkg::NCH-1:0]    timer_io_pin_in,
  output logic      [2*scct_pkg::NCH-1:0]    timer_io_pin_out,
  output logic      [2*scct_pkg::NCH-1:0]    timer_io_pin_oe_n_out,
  // Interrupt requests
  output logic      [2*scct_pkg::NCH-1:0]    irq_match_out,
  output logic      [scct_pkg::NCH-1:0]      irq_ovf_out
);
  import scct_pkg::*;

  logic [7:0]                start_q, start_d, sync_q, sync_d;
  logic [NCH-1:0][7:0]       ctrl_q, ctrl_d, ioc_q, ioc_d, ier_q, ier_d, flag_q, flag_d;
  logic [DW-1:0]             rdata_q, rdata_d;
  logic [NCH-1:0][CW-1:0]    cnt, gra, grb;
  logic [NCH-1:0][1:0]       evt, gr_wr;
  logic [NCH-1:0]            mclr, ovf, cnt_wr, load_en, sync_clr;
  logic                      any_sync_wr;

  // ----------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------
  function automatic logic [AW-1:0] ch_ofs(input int c, input logic [7:0] ofs);
    return AW'(CH_STRIDE * (c + 1) + int'(ofs));
  endfunction : ch_ofs

  function automatic logic byte_wr(input logic [AW-1:0] ofs);
    return bus_wr_in && (bus_addr_in[AW-1:1] == ofs[AW-1:1]) && (ofs[0] ? bus_be_in[0] : bus_be_in[1]);
  endfunction : byte_wr

  function automatic logic [7:0] byte_data(input logic [AW-1:0] ofs);
    return ofs[0] ? bus_wdata_in[7:0] : bus_wdata_in[15:8];
  endfunction : byte_data

  function automatic logic word_hit(input logic [AW-1:0] ofs);
    return bus_addr_in[AW-1:1] == ofs[AW-1:1];
  endfunction : word_hit

  // ----------------------------------------------------------
  // Synchronous preset and clear
  // ----------------------------------------------------------
  always_comb begin
    any_sync_wr = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      cnt_wr[c]   = bus_wr_in && word_hit(ch_ofs(c, OFS_CNT)) && bus_be_in == 2'h3;
      gr_wr[c][0] = bus_wr_in && word_hit(ch_ofs(c, OFS_GRA)) && bus_be_in == 2'h3;
      gr_wr[c][1] = bus_wr_in && word_hit(ch_ofs(c, OFS_GRB)) && bus_be_in == 2'h3;
      any_sync_wr = any_sync_wr | (cnt_wr[c] & sync_q[c+1]);
    end
    for (int c = 0; c < NCH; c++) begin
      load_en[c]  = cnt_wr[c] | (sync_q[c+1] & any_sync_wr);
      sync_clr[c] = 1'b0;
      for (int k = 0; k < NCH; k++) begin
        if (k != c) sync_clr[c] = sync_clr[c] | (sync_q[c+1] & sync_q[k+1] & mclr[k]);
      end
    end
  end

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  always_comb begin
    logic [7:0] f;
    f       = '0;
    start_d = start_q;
    sync_d  = sync_q;
    ctrl_d  = ctrl_q;
    ioc_d   = ioc_q;
    ier_d   = ier_q;
    if (byte_wr(OFS_START)) start_d = byte_data(OFS_START) & START_MASK;
    if (byte_wr(OFS_SYNC)) sync_d = byte_data(OFS_SYNC) & SYNC_MASK;
    for (int c = 0; c < NCH; c++) begin
      if (byte_wr(ch_ofs(c, OFS_CTRL))) ctrl_d[c] = byte_data(ch_ofs(c, OFS_CTRL)) & CTRL_MASK;
      if (byte_wr(ch_ofs(c, OFS_IOC))) ioc_d[c] = byte_data(ch_ofs(c, OFS_IOC));
      if (byte_wr(ch_ofs(c, OFS_IER))) ier_d[c] = byte_data(ch_ofs(c, OFS_IER)) & IER_MASK;
      f = flag_q[c];
      if (byte_wr(ch_ofs(c, OFS_FLAG))) f = f & byte_data(ch_ofs(c, OFS_FLAG));
      f[1:0]      = f[1:0] | evt[c];
      f[FLAG_OVF] = f[FLAG_OVF] | ovf[c];
      flag_d[c]   = f & FLAG_MASK;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (bus_rd_in) begin
      rdata_d = '0;
      if (word_hit(OFS_START)) rdata_d = {start_q, sync_q};
      for (int c = 0; c < NCH; c++) begin
        if (word_hit(ch_ofs(c, OFS_CTRL))) rdata_d = {ctrl_q[c], ioc_q[c]};
        if (word_hit(ch_ofs(c, OFS_IER))) rdata_d = {ier_q[c], flag_q[c]};
        if (word_hit(ch_ofs(c, OFS_CNT))) rdata_d = cnt[c];
        if (word_hit(ch_ofs(c, OFS_GRA))) rdata_d = gra[c];
        if (word_hit(ch_ofs(c, OFS_GRB))) rdata_d = grb[c];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_q <= REG_RST;
      sync_q  <= REG_RST;
      ctrl_q  <= '{default: REG_RST};
      ioc_q   <= '{default: REG_RST};
      ier_q   <= '{default: REG_RST};
      flag_q  <= '{default: REG_RST};
      rdata_q <= '0;
    end else begin
      start_q <= start_d;
      sync_q  <= sync_d;
      ctrl_q  <= ctrl_d;
      ioc_q   <= ioc_d;
      ier_q   <= ier_d;
      flag_q  <= flag_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata_out = rdata_q;

  // ----------------------------------------------------------
  // Channels
  // ----------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    scct_channel u_ch (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .run_in        (start_q[c+1]),
      .clr_src_in    (scct_clr_type'(ctrl_q[c][1:0])),
      .ioc_in        (ioc_q[c]),
      .sync_clr_in   (sync_clr[c]),
      .load_en_in    (load_en[c]),
      .wdata_in      (bus_wdata_in),
      .gr_wr_in      (gr_wr[c]),
      .pin_in        (timer_io_pin_in[2*c +: 2]),
      .pin_out       (timer_io_pin_out[2*c +: 2]),
      .pin_oe_n_out  (timer_io_pin_oe_n_out[2*c +: 2]),
      .count_out     (cnt[c]),
      .gra_out       (gra[c]),
      .grb_out       (grb[c]),
      .event_out     (evt[c]),
      .match_clr_out (mclr[c]),
      .ovf_out       (ovf[c])
    );
    assign irq_match_out[2*c +: 2] = flag_q[c][1:0] & ier_q[c][1:0];
    assign irq_ovf_out[c]          = flag_q[c][FLAG_OVF] & ier_q[c][FLAG_OVF];
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_sync_preset;
    @(posedge clock_in) disable iff (!rst_n_in)
    cnt_wr[0] && sync_q[1] && sync_q[2] |=> cnt[0] == $past(bus_wdata_in) && cnt[1] == $past(bus_wdata_in);
  endproperty
  a_sync_preset: assert property (p_sync_preset) else $error("synchronous preset missed");

  property p_reserved;
    @(posedge clock_in) disable iff (!rst_n_in)
    byte_wr(OFS_SYNC) |=> (sync_q & ~SYNC_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved sync bits set");

  property p_ovf_flag;
    @(posedge clock_in) disable iff (!rst_n_in)
    ovf[0] |=> flag_q[0][FLAG_OVF] ##0 (irq_ovf_out[0] == ier_q[0][FLAG_OVF]);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag or request wrong");

  property p_sticky;
    @(posedge clock_in) disable iff (!rst_n_in)
    flag_q[0][0] && !byte_wr(ch_ofs(0, OFS_FLAG)) |=> flag_q[0][0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_sync_clear;
    @(posedge clock_in) disable iff (!rst_n_in)
    sync_clr[1] && ctrl_q[1][1:0] == 2'h3 && !load_en[1] |=> cnt[1] == CNT_RST;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

  c_overflow:   cover property (@(posedge clock_in) disable iff (!rst_n_in) ovf[0]);
  c_sync_clear: cover property (@(posedge clock_in) disable iff (!rst_n_in) sync_clr[1]);
  c_capture:    cover property (@(posedge clock_in) disable iff (!rst_n_in) evt[0][1] && ioc_q[0][IOC_W+IOC_CAPT]);
endmodule : scct_timer
`default_nettype wire

// ### src/scct_pkg.sv
`default_nettype none
package scct_pkg;
  localparam int          NCH        = 2;
  localparam int          CW         = 16;
  localparam int          AW         = 8;
  localparam int          DW         = 16;
  localparam int          NGR        = 2;
  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0]  OFS_START  = 8'h00;
  localparam logic [7:0]  OFS_SYNC   = 8'h01;
  localparam int          CH_STRIDE  = 16;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_IOC    = 8'h01;
  localparam logic [7:0]  OFS_IER    = 8'h02;
  localparam logic [7:0]  OFS_FLAG   = 8'h03;
  localparam logic [7:0]  OFS_CNT    = 8'h04;
  localparam logic [7:0]  OFS_GRA    = 8'h06;
  localparam logic [7:0]  OFS_GRB    = 8'h08;
  // ----------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------
  localparam logic [7:0]  SYNC_MASK  = 8'h06;
  localparam logic [7:0]  START_MASK = 8'h06;
  localparam logic [7:0]  IER_MASK   = 8'h13;
  localparam logic [7:0]  FLAG_MASK  = 8'h13;
  localparam logic [7:0]  CTRL_MASK  = 8'h03;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam int          FLAG_OVF   = 4;
  localparam int          IOC_W      = 4;
  localparam int          IOC_CAPT   = 3;
  localparam logic [1:0]  OUT_NONE   = 2'h0;
  localparam logic [1:0]  OUT_LOW    = 2'h1;
  localparam logic [1:0]  OUT_HIGH   = 2'h2;
  localparam logic [1:0]  EDGE_RISE  = 2'h0;
  localparam logic [1:0]  EDGE_FALL  = 2'h1;
  typedef enum logic [1:0] {
    SCCT_CLR_NONE,
    SCCT_CLR_MATCH_A,
    SCCT_CLR_MATCH_B,
    SCCT_CLR_SYNC
  } scct_clr_type;
endpackage : scct_pkg
`default_nettype wire

// ### src/scct_channel.sv
`timescale 1ns/10ps
`default_nettype none
module scct_channel (
  // Clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  // Control
  input  wire logic                      run_in,
  input  wire scct_pkg::scct_clr_type    clr_src_in,
  input  wire logic [7:0]                ioc_in,
  input  wire logic                      sync_clr_in,
  // Counter and general register writes
  input  wire logic                      load_en_in,
  input  wire logic [scct_pkg::CW-1:0]   wdata_in,
  input  wire logic [1:0]                gr_wr_in,
  // Pins
  input  wire logic [1:0]                pin_in,
  output logic      [1:0]                pin_out,
  output logic      [1:0]                pin_oe_n_out,
  // State and events
  output logic      [scct_pkg::CW-1:0]   count_out,
  output logic      [scct_pkg::CW-1:0]   gra_out,
  output logic      [scct_pkg::CW-1:0]   grb_out,
  output logic      [1:0]                event_out,
  output logic                           match_clr_out,
  output logic                           ovf_out
);
  import scct_pkg::*;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] gr_q [NGR];
  logic [CW-1:0] gr_d [NGR];
  logic [1:0]    pin_q, pin_d, prev_q, prev_d;
  logic [1:0]    match, capt;
  logic          clr_now;

  // ----------------------------------------------------------
  // Compare, capture and counter
  // ----------------------------------------------------------
  always_comb begin
    logic [IOC_W-1:0] f;
    f             = '0;
    match         = '0;
    capt          = '0;
    pin_d         = pin_q;
    prev_d        = pin_in;
    for (int i = 0; i < NGR; i++) begin
      f           = ioc_in[i*IOC_W +: IOC_W];
      gr_d[i]     = gr_q[i];
      if (f[IOC_CAPT]) begin
        pin_oe_n_out[i] = 1'b1;
        if (f[1:0] == EDGE_RISE) capt[i] = pin_in[i] & ~prev_q[i];
        else if (f[1:0] == EDGE_FALL) capt[i] = ~pin_in[i] & prev_q[i];
        else capt[i] = pin_in[i] ^ prev_q[i];
      end else begin
        pin_oe_n_out[i] = (f[1:0] == OUT_NONE);
        match[i]  = run_in && (cnt_q == gr_q[i]);
        if (match[i]) begin
          case (f[1:0])
            OUT_LOW:  pin_d[i] = 1'b0;
            OUT_HIGH: pin_d[i] = 1'b1;
            OUT_NONE: pin_d[i] = pin_q[i];
            default:  pin_d[i] = ~pin_q[i];
          endcase
        end
      end
      if (capt[i]) gr_d[i] = cnt_q;
      else if (gr_wr_in[i]) gr_d[i] = wdata_in;
    end
    event_out     = match | capt;
    match_clr_out = (clr_src_in == SCCT_CLR_MATCH_A && event_out[0]) ||
                    (clr_src_in == SCCT_CLR_MATCH_B && event_out[1]);
    clr_now       = match_clr_out || (clr_src_in == SCCT_CLR_SYNC && sync_clr_in);
    ovf_out       = 1'b0;
    cnt_d         = cnt_q;
    if (load_en_in) cnt_d = wdata_in;
    else if (clr_now) cnt_d = CNT_RST;
    else if (run_in) begin
      cnt_d       = cnt_q + 16'h0001;
      ovf_out     = (cnt_q == CNT_MAX);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q  <= CNT_RST;
      gr_q   <= '{default: 16'hffff};
      pin_q  <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      cnt_q  <= cnt_d;
      gr_q   <= gr_d;
      pin_q  <= pin_d;
      prev_q <= prev_d;
    end
  end

  assign count_out = cnt_q;
  assign gra_out   = gr_q[0];
  assign grb_out   = gr_q[1];
  assign pin_out   = pin_q;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_count_inc;
    @(posedge clock_in) disable iff (!rst_n_in)
    run_in && !load_en_in && !clr_now |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not step by one");

  property p_stopped;
    @(posedge clock_in) disable iff (!rst_n_in)
    !run_in && !load_en_in && !clr_now |=> $stable(cnt_q) && $stable(pin_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter or pin moved");

  property p_match_clear;
    @(posedge clock_in) disable iff (!rst_n_in)
    match_clr_out && !load_en_in |=> cnt_q == CNT_RST;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear counter");

  property p_capture;
    @(posedge clock_in) disable iff (!rst_n_in)
    capt[1] |=> gr_q[1] == $past(cnt_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost counter value");

  property p_high_out;
    @(posedge clock_in) disable iff (!rst_n_in)
    match[0] && ioc_in[1:0] == OUT_HIGH |=> pin_q[0];
  endproperty
  a_high_out: assert property (p_high_out) else $error("pin not high after match");
endmodule : scct_channel
`default_nettype wire

// ### testbench/scct_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module scct_cpu_model (
  // Clock
  input  wire logic                    clock_in,
  // Bus requests
  output logic [scct_pkg::AW-1:0]      bus_addr_out,
  output logic                         bus_wr_out,
  output logic                         bus_rd_out,
  output logic [1:0]                   bus_be_out,
  output logic [scct_pkg::DW-1:0]      bus_wdata_out
);
  import scct_pkg::*;
  initial begin
    bus_addr_out  = 8'h00;
    bus_wr_out    = 1'b0;
    bus_rd_out    = 1'b0;
    bus_be_out    = 2'b00;
    bus_wdata_out = 16'h0000;
  end
  // -----------------------------------------------------------
  // One bus cycle, held until the taking edge
  // -----------------------------------------------------------
  task automatic access(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] data,
                        input logic wr, input logic strict);
    logic [1:0]  be_v;
    logic [15:0] data_v;
    be_v   = be;
    data_v = data;
    if (strict && addr[7:4] != 4'h0 && addr[3:0] >= 4'h4) begin
      be_v = 2'b11;
    end
    if (strict && addr[7:1] == 7'h00) begin
      data_v[7:0] = data[7:0] & SYNC_MASK;
    end
    @(posedge clock_in);
    #1;
    bus_addr_out  = addr;
    bus_be_out    = be_v;
    bus_wdata_out = data_v;
    bus_wr_out    = wr;
    bus_rd_out    = ~wr;
    @(posedge clock_in);
    #1;
    // Released address, byte enables and data show the inverse so stale values never pass; write and read drop to 0
    bus_wr_out    = 1'b0;
    bus_rd_out    = 1'b0;
    bus_addr_out  = ~bus_addr_out;
    bus_be_out    = ~bus_be_out;
    bus_wdata_out = ~bus_wdata_out;
  endtask : access
endmodule : scct_cpu_model
`default_nettype wire

// ### testbench/scct_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module scct_timer_test;
  import scct_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [3:0]  pin_drv = 4'h0;
  wire  [3:0]  pin_wire;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe_n;
  logic [3:0]  irq_m;
  logic [1:0]  irq_o;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [15:0] exp_q[$];
  logic        rd_seen = 1'b0;
  logic [15:0] g;
  logic [15:0] r;
  always #10 clock_in = ~clock_in;
  assign pin_wire = (pin_drv & pin_oe_n) | (pin_out & ~pin_oe_n);
  scct_cpu_model cpu (.clock_in(clock_in), .bus_addr_out(addr), .bus_wr_out(wr), .bus_rd_out(rd),
                      .bus_be_out(be), .bus_wdata_out(wdata));
  scct_timer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_addr_in(addr), .bus_wr_in(wr),
                  .bus_rd_in(rd), .bus_be_in(be), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
                  .timer_io_pin_in(pin_wire), .timer_io_pin_out(pin_out),
                  .timer_io_pin_oe_n_out(pin_oe_n), .irq_match_out(irq_m), .irq_ovf_out(irq_o));
  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic wrb(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d, input logic s);
    cpu.access(a, b, d, 1'b1, s);
  endtask : wrb
  task automatic rdx(input logic [7:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    cpu.access(a, 2'b11, 16'h0000, 1'b0, 1'b1);
  endtask : rdx
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_cyc
  // Read data is compared one edge after the taking edge
  always @(posedge clock_in) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
  end
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  initial begin
    void'($urandom(32'h5afd));
    repeat (8) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    rdx(8'h00, 16'h0000);
    rdx(8'h10, 16'h0000);
    rdx(8'h16, 16'hffff);
    wrb(8'h40, 2'b11, 16'hffff, 1'b1);
    rdx(8'h40, 16'h0000);
    wrb(8'h01, 2'b01, 16'h00ff, 1'b0);
    rdx(8'h00, 16'h0006);
    wrb(8'h14, 2'b11, 16'h1234, 1'b1);
    rdx(8'h24, 16'h1234);
    wrb(8'h01, 2'b01, 16'h0002, 1'b1);
    wrb(8'h14, 2'b11, 16'h5555, 1'b1);
    rdx(8'h24, 16'h1234);
    wrb(8'h14, 2'b01, 16'h00aa, 1'b0);
    rdx(8'h14, 16'h5555);
    // Overflow, sticky flag and request
    wrb(8'h12, 2'b10, 16'h1000, 1'b1);
    wrb(8'h14, 2'b11, 16'hfffd, 1'b1);
    wrb(8'h00, 2'b10, 16'h0200, 1'b1);
    wait_cyc(4);
    check({14'h0, irq_o}, 16'h0001);
    rdx(8'h12, 16'h1013);
    wrb(8'h12, 2'b01, 16'h0000, 1'b1);
    check({14'h0, irq_o}, 16'h0000);
    wrb(8'h00, 2'b10, 16'h0000, 1'b1);
    rdx(8'h14, 16'h0007);
    rdx(8'h14, 16'h0007);
    // Periodic toggle with synchronous clearing
    wrb(8'h10, 2'b11, 16'h0103, 1'b1);
    wrb(8'h16, 2'b11, 16'h0004, 1'b1);
    wrb(8'h20, 2'b11, 16'h0300, 1'b1);
    wrb(8'h01, 2'b01, 16'h0006, 1'b1);
    wrb(8'h12, 2'b10, 16'h0100, 1'b1);
    wrb(8'h14, 2'b11, 16'h0000, 1'b1);
    wrb(8'h00, 2'b10, 16'h0600, 1'b1);
    rdx(8'h14, 16'h0001);
    rdx(8'h24, 16'h0003);
    rdx(8'h14, 16'h0000);
    wrb(8'h00, 2'b10, 16'h0000, 1'b1);
    wait_cyc(3);
    check({8'h0, pin_out, irq_m}, {8'h0, 4'b0001, 4'b0001});
    check({12'h0, pin_oe_n}, 16'h000e);
    rdx(8'h14, 16'h0003);
    rdx(8'h24, 16'h0003);
    // Fixed levels on channel 2, repeated level leaves the pin
    wrb(8'h01, 2'b01, 16'h0000, 1'b1);
    wrb(8'h26, 2'b11, 16'h0002, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wrb(8'h20, 2'b11, (i < 2) ? 16'h0102 : 16'h0101, 1'b1);
      wrb(8'h24, 2'b11, 16'h0000, 1'b1);
      wrb(8'h00, 2'b10, 16'h0400, 1'b1);
      wait_cyc(3);
      wrb(8'h00, 2'b10, 16'h0000, 1'b1);
      wait_cyc(2);
      check({12'h0, pin_out}, {12'h0, 1'b0, (i < 2), 2'b01});
    end
    // Capture on channel 1 register B for each edge choice
    g = 16'hffff;
    for (int e = 0; e < 3; e++) begin
      wrb(8'h10, 2'b11, {8'h00, 2'b10, 2'(e), 4'h3}, 1'b1);
      r = 16'($urandom);
      wrb(8'h14, 2'b11, r, 1'b1);
      pin_drv[1] = 1'b1;
      wait_cyc(3);
      g = (e != 1) ? r : g;
      rdx(8'h18, g);
      r = 16'($urandom);
      wrb(8'h14, 2'b11, r, 1'b1);
      pin_drv[1] = 1'b0;
      wait_cyc(3);
      g = (e != 0) ? r : g;
      rdx(8'h18, g);
    end
    // Periodic counting on channel 2 cleared by register B match
    wrb(8'h20, 2'b11, 16'h0200, 1'b1);
    wrb(8'h28, 2'b11, 16'h0003, 1'b1);
    wrb(8'h24, 2'b11, 16'h0000, 1'b1);
    wrb(8'h00, 2'b10, 16'h0400, 1'b1);
    rdx(8'h24, 16'h0001);
    rdx(8'h24, 16'h0003);
    rdx(8'h24, 16'h0001);
    wrb(8'h00, 2'b10, 16'h0000, 1'b1);
    rdx(8'h12, 16'h0103);
    wrb(8'h12, 2'b10, 16'h0300, 1'b1);
    check({12'h0, irq_m}, 16'h0003);
    wrb(8'h12, 2'b01, 16'h0002, 1'b1);
    check({12'h0, irq_m}, 16'h0002);
    wait_cyc(3);
    print_verdict();
  end
endmodule : scct_timer_test
`default_nettype wire
